// ===== msg_defs.vh
// Register indices, field positions, clock select codes, reset values and bus answers for the motor signal generator.
`ifndef MSG_DEFS_VH
`define MSG_DEFS_VH

// ----------
// Register indices (byte address is four times the index)
// ----------
`define MSG_IDX_CTL        16'h7F80
`define MSG_IDX_STEP       16'h7F81
`define MSG_IDX_PER_LO     16'h7F82
`define MSG_IDX_PER_HI     16'h7F83
`define MSG_IDX_DLY_LO     16'h7F84
`define MSG_IDX_DLY_HI     16'h7F85

// ----------
// Control register fields
// ----------
`define MSG_CTL_STOPF      7
`define MSG_CTL_OVF        6
`define MSG_CTL_MATCHF     5
`define MSG_CTL_IE         4
`define MSG_CTL_COUNT_CLOCK_SELECT_HI    3
`define MSG_CTL_COUNT_CLOCK_SELECT_LO    2
`define MSG_CTL_DIR        1
`define MSG_CTL_RUN        0

// ----------
// Period high and delay high register fields
// ----------
`define MSG_PHI_STEPPING_DIRECTION       7
`define MSG_PHI_STOP       6
`define MSG_PHI_MASK       8'hCF
`define MSG_DHI_MASK       8'h03

// ----------
// Clock select codes
// ----------
`define MSG_COUNT_CLOCK_SELECT_SYS       2'h0
`define MSG_COUNT_CLOCK_SELECT_TMR3      2'h1
`define MSG_COUNT_CLOCK_SELECT_PLL       2'h2
`define MSG_COUNT_CLOCK_SELECT_OSC       2'h3

// ----------
// Reset values and bus answers
// ----------
`define MSG_RST_BYTE       8'h00
`define MSG_RESP_OKAY      2'h0
`define MSG_RESP_SLVERR    2'h2

`endif

// ===== msg_motor_signal_generator.v
// Motor signal generator: AXI4-Lite registers, step and period counters, waveform outputs.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
//
// Functional notes
// [R1] Step counter advances once per output step.
// [R2] Counter wrap FF to 00 sets overflow.
// [R3] Counter equal to buffer: match, clear counter.
// [R4] Zero setting: no match, counter runs free.
// [R5] Stop flag set: step register reads counter.
// [R6] Stepping holds setting for setting plus one.
// [R7] Step buffer follows idle, loads on match.
// [R8] Stepping period is ten bits, reload one.
// [R9] Ultrasonic period is twelve bits, four phases.
// [R10] Period buffer load depends on step setting.
// [R11] Rise of each output delayed by low period.
// [R12] Low period buffer loads with period buffer.
// [R13] Stop request loaded sets stop flag.
// [R14] Step match sets match flag, never zero.
// [R15] Interrupt when enabled and any flag set.
// [R16] Clock select picks period count clock.
// [R17] Timer 3 tick follows timer 3 width.
// [R18] Ultrasonic direction bit reverses phase order.
// [R19] Run starts; clearing run drives outputs low.
// [R20] Stepping stop: outputs low two cycles later.
// [R21] Ultrasonic stop: outputs low two cycles later.
// [R22] Software keeps unused fields zero per mode.
// [R23] Stepping direction bit reverses step order.
// [R24] Loaded stop request halts stepping outputs.
// [R25] PLL select means ultrasonic, else stepping.
`include "msg_defs.vh"

module msg_motor_signal_generator #(
    parameter ADDR_W = 18
) (
    input  wire              clk,
    input  wire              rstn,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire              timer3_full_match,
    input  wire              timer3_high_match,
    input  wire              timer3_16bit_mode,
    input  wire              pll_clock_in,
    input  wire              low_freq_oscillator,
    output reg               motor_out_0,
    output reg               motor_out_1,
    output reg               motor_out_2,
    output reg               motor_out_3,
    output reg               irq_request
);

    // ----------
    // Functions
    // ----------
    function [15:0] word_index;
        input [ADDR_W-1:0] addr;
        begin
            word_index = addr[17:2];
        end
    endfunction

    function mapped;
        input [15:0] idx;
        begin
            mapped = (idx >= `MSG_IDX_CTL) && (idx <= `MSG_IDX_DLY_HI);
        end
    endfunction

    // ----------
    // Registers
    // ----------
    reg [7:0]        ctl_reg;
    reg [7:0]        step_set_reg;
    reg [7:0]        per_lo_reg;
    reg [7:0]        per_hi_reg;
    reg [7:0]        dly_lo_reg;
    reg [7:0]        dly_hi_reg;
    reg [7:0]        step_buf_reg;
    reg [13:0]       per_buf_reg;
    reg [9:0]        dly_buf_reg;
    reg [7:0]        step_cnt_reg;
    reg [11:0]       per_cnt_reg;
    reg [9:0]        dly_cnt_reg;
    reg [1:0]        pos_reg;
    reg [1:0]        last_phase_reg;
    reg              aw_full_reg;
    reg              w_full_reg;
    reg [ADDR_W-1:0] aw_addr_reg;
    reg [31:0]       w_data_reg;
    reg [3:0]        w_strb_reg;
    reg [2:0]        pll_sync_reg;
    reg [2:0]        osc_sync_reg;

    // ----------
    // Bus handshakes
    // ----------
    assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire        wr_go  = aw_full_reg && w_full_reg && !s_axi_bvalid;
    wire [15:0] wr_idx = word_index(aw_addr_reg);
    wire        wr_ok  = wr_go && mapped(wr_idx) && w_strb_reg[0];
    wire [7:0]  wbyte  = w_data_reg[7:0];
    wire        wr_ctl = wr_ok && (wr_idx == `MSG_IDX_CTL);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            aw_addr_reg  <= {ADDR_W{1'b0}};
            w_data_reg   <= 32'h00000000;
            w_strb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `MSG_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(wr_idx) ? `MSG_RESP_OKAY : `MSG_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------
    // Count clock selection
    // ----------
    wire       run        = ctl_reg[`MSG_CTL_RUN];
    wire [1:0] count_clock_select       = ctl_reg[`MSG_CTL_COUNT_CLOCK_SELECT_HI:`MSG_CTL_COUNT_CLOCK_SELECT_LO];
    wire       ultrasonic = (count_clock_select == `MSG_COUNT_CLOCK_SELECT_PLL); // [R25]
    wire       pll_tick   = pll_sync_reg[1] && !pll_sync_reg[2];
    wire       osc_tick   = osc_sync_reg[1] && !osc_sync_reg[2];
    wire       tmr3_tick  = timer3_16bit_mode ? timer3_full_match : timer3_high_match; // [R17]
    reg        tick;

    always @* begin
        case (count_clock_select) // [R16]
            `MSG_COUNT_CLOCK_SELECT_SYS:  tick = 1'b1;
            `MSG_COUNT_CLOCK_SELECT_TMR3: tick = tmr3_tick;
            `MSG_COUNT_CLOCK_SELECT_PLL:  tick = pll_tick;
            `MSG_COUNT_CLOCK_SELECT_OSC:  tick = osc_tick;
            default:        tick = 1'b0;
        endcase
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pll_sync_reg <= 3'h0;
            osc_sync_reg <= 3'h0;
        end else begin
            pll_sync_reg <= {pll_sync_reg[1:0], pll_clock_in};
            osc_sync_reg <= {osc_sync_reg[1:0], low_freq_oscillator};
        end
    end

    // ----------
    // Period counter and step counter
    // ----------
    wire [11:0] per_target = ultrasonic ? per_buf_reg[11:0] // [R9]
                                        : {2'h0, per_buf_reg[11:2]}; // [R8]
    wire        stop_buf   = per_buf_reg[`MSG_PHI_STOP + 6];
    wire        stepping_direction_buf   = per_buf_reg[`MSG_PHI_STEPPING_DIRECTION + 6];
    wire        per_match  = run && tick && (per_cnt_reg >= per_target);
    wire        advance    = per_match && !ultrasonic && !stop_buf; // [R24]
    wire        step_match = advance && (step_buf_reg != 8'h00)
                             && (step_cnt_reg == step_buf_reg); // [R3] [R4]
    wire        wrap       = advance && !step_match && (step_cnt_reg == 8'hFF);
    wire        buf_load   = !run || (per_match
                             && ((step_buf_reg == 8'h00) || step_match)); // [R10]
    wire [13:0] per_new    = {per_hi_reg[7:6], per_hi_reg[3:0], per_lo_reg};

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            per_cnt_reg  <= 12'h001;
            step_cnt_reg <= 8'h00;
            pos_reg      <= 2'h0;
        end else if (!run) begin
            per_cnt_reg  <= 12'h001;
            step_cnt_reg <= 8'h00;
            pos_reg      <= 2'h0;
        end else begin
            if (per_match)
                per_cnt_reg <= 12'h001; // [R8]
            else if (tick)
                per_cnt_reg <= per_cnt_reg + 12'h001;
            if (step_match)
                step_cnt_reg <= 8'h00; // [R3] [R6]
            else if (advance)
                step_cnt_reg <= step_cnt_reg + 8'h01; // [R1] [R2]
            if (advance)
                pos_reg <= stepping_direction_buf ? pos_reg - 2'h1 : pos_reg + 2'h1; // [R23]
        end
    end

    // ----------
    // Setting buffers
    // ----------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            step_buf_reg <= `MSG_RST_BYTE;
            per_buf_reg  <= 14'h0000;
            dly_buf_reg  <= 10'h000;
        end else begin
            if (!run || step_match)
                step_buf_reg <= step_set_reg; // [R7]
            if (buf_load) begin
                per_buf_reg <= per_new; // [R10]
                dly_buf_reg <= {dly_hi_reg[1:0], dly_lo_reg}; // [R12]
            end
        end
    end

    wire stop_taken = run && buf_load && per_new[`MSG_PHI_STOP + 6] && !stop_buf; // [R13]

    // ----------
    // Register writes and flags
    // ----------
    reg [7:0] ctl_next;

    always @* begin
        ctl_next = ctl_reg;
        if (wr_ctl) begin
            ctl_next[4:0] = wbyte[4:0];
            ctl_next[7:5] = ctl_reg[7:5] & wbyte[7:5];
        end
        if (stop_taken)
            ctl_next[`MSG_CTL_STOPF] = 1'b1; // [R13]
        if (wrap)
            ctl_next[`MSG_CTL_OVF] = 1'b1; // [R2]
        if (step_match)
            ctl_next[`MSG_CTL_MATCHF] = 1'b1; // [R14]
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctl_reg      <= `MSG_RST_BYTE;
            step_set_reg <= `MSG_RST_BYTE;
            per_lo_reg   <= `MSG_RST_BYTE;
            per_hi_reg   <= `MSG_RST_BYTE;
            dly_lo_reg   <= `MSG_RST_BYTE;
            dly_hi_reg   <= `MSG_RST_BYTE;
        end else begin
            ctl_reg <= ctl_next; // [R19]
            if (wr_ok && wr_idx == `MSG_IDX_STEP)
                step_set_reg <= wbyte;
            if (wr_ok && wr_idx == `MSG_IDX_PER_LO)
                per_lo_reg <= wbyte;
            if (wr_ok && wr_idx == `MSG_IDX_PER_HI)
                per_hi_reg <= wbyte & `MSG_PHI_MASK;
            if (wr_ok && wr_idx == `MSG_IDX_DLY_LO)
                dly_lo_reg <= wbyte;
            if (wr_ok && wr_idx == `MSG_IDX_DLY_HI)
                dly_hi_reg <= wbyte & `MSG_DHI_MASK;
        end
    end

    // ----------
    // Register reads
    // ----------
    wire [15:0] rd_idx = word_index(s_axi_araddr);
    reg  [7:0]  rd_byte;

    always @* begin
        case (rd_idx)
            `MSG_IDX_CTL:    rd_byte = ctl_reg;
            `MSG_IDX_STEP:   rd_byte = ctl_reg[`MSG_CTL_STOPF] ? step_cnt_reg
                                                                : step_set_reg; // [R5]
            `MSG_IDX_PER_LO: rd_byte = per_lo_reg;
            `MSG_IDX_PER_HI: rd_byte = per_hi_reg;
            `MSG_IDX_DLY_LO: rd_byte = dly_lo_reg;
            `MSG_IDX_DLY_HI: rd_byte = dly_hi_reg;
            default:         rd_byte = 8'h00;
        endcase
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `MSG_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte};
            s_axi_rresp  <= mapped(rd_idx) ? `MSG_RESP_OKAY : `MSG_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------
    // Waveform generation
    // ----------
    wire [11:0] quarter = {2'h0, per_target[11:2]};
    reg  [1:0]  us_phase;
    reg  [1:0]  phase;

    always @* begin
        if (per_cnt_reg > quarter + quarter + quarter)
            us_phase = 2'h3;
        else if (per_cnt_reg > quarter + quarter)
            us_phase = 2'h2;
        else if (per_cnt_reg > quarter)
            us_phase = 2'h1;
        else
            us_phase = 2'h0;
        if (ultrasonic)
            phase = ctl_reg[`MSG_CTL_DIR] ? 2'h3 - us_phase : us_phase; // [R18]
        else
            phase = pos_reg;
    end

    wire phase_changed = (phase != last_phase_reg);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last_phase_reg <= 2'h0;
            dly_cnt_reg    <= 10'h000;
        end else begin
            last_phase_reg <= phase;
            if (!run || phase_changed)
                dly_cnt_reg <= 10'h000;
            else if (tick && dly_cnt_reg != 10'h3FF)
                dly_cnt_reg <= dly_cnt_reg + 10'h001; // [R11]
        end
    end

    wire drive = run && !phase_changed && (dly_cnt_reg >= dly_buf_reg) // [R11]
                 && (ultrasonic || !stop_buf); // [R24]

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            motor_out_0 <= 1'b0;
            motor_out_1 <= 1'b0;
            motor_out_2 <= 1'b0;
            motor_out_3 <= 1'b0;
            irq_request <= 1'b0;
        end else begin
            motor_out_0 <= drive && (phase == 2'h0); // [R19] [R20] [R21]
            motor_out_1 <= drive && (phase == 2'h1);
            motor_out_2 <= drive && (phase == 2'h2);
            motor_out_3 <= drive && (phase == 2'h3);
            irq_request <= ctl_reg[`MSG_CTL_IE] && (|ctl_reg[7:5]); // [R15]
        end
    end

endmodule

// ===== msg_motor_signal_generator_checker.sv
// Concurrent checks on the bus answers and motor outputs of the motor signal generator.
`timescale 1ns/1ps
`include "msg_defs.vh"
module msg_motor_signal_generator_checker #(
    parameter ADDR_W = 18
) (
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              motor_out_0,
    input wire logic              motor_out_1,
    input wire logic              motor_out_2,
    input wire logic              motor_out_3,
    input wire logic              irq_request
);
    localparam logic [ADDR_W-1:0] CTL_A = `MSG_IDX_CTL * 4;
    localparam logic [ADDR_W-1:0] TOP_A = `MSG_IDX_DLY_HI * 4;
    wire [3:0] outs = {motor_out_3, motor_out_2, motor_out_1, motor_out_0};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ----------
    // Properties
    // ----------
    sequence s_run_clear;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_awaddr == CTL_A && !s_axi_wdata[0];
    endsequence
    sequence s_outs_low;
        outs == 4'h0;
    endsequence
    property p_run_clear; s_run_clear |=> ##[1:2] s_outs_low; endproperty
    property p_one_phase; $onehot0(outs); endproperty
    property p_reset_quiet; $rose(rstn) |-> outs == 4'h0 && !irq_request; endproperty
    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
    endproperty
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_refuse;
        (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
            and (s_axi_rvalid |-> !s_axi_arready);
    endproperty
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && (s_axi_araddr < CTL_A || s_axi_araddr > TOP_A)
            |=> s_axi_rresp == `MSG_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    property p_byte_wide; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    // ----------
    // Assertions
    // ----------
    a_run_clear: assert property (p_run_clear) else $error("outputs not low after stop");
    a_one_phase: assert property (p_one_phase) else $error("several phases active");
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy at reset");
    a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_rd_answer: assert property (p_rd_answer) else $error("read data missing");
    a_r_hold: assert property (p_r_hold) else $error("read data changed");
    a_refuse: assert property (p_refuse) else $error("request taken while busy");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
    a_byte_wide: assert property (p_byte_wide) else $error("upper read bits set");
endmodule
bind msg_motor_signal_generator msg_motor_signal_generator_checker #(.ADDR_W(ADDR_W)) u_chk (
    .clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .motor_out_0, .motor_out_1,
    .motor_out_2, .motor_out_3, .irq_request);

// ===== msg_motor_driver_model.sv
// Behavioural motor driver that counts the steps it receives and their order.
`timescale 1ns/1ps
module msg_motor_driver_model (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [3:0] phases,
    output int              steps,
    output int              step_delta
);
    int         last_idx;
    int         idx;
    logic [3:0] last_pat;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            steps <= 0;
            step_delta <= 0;
            last_idx <= 0;
            last_pat <= 4'h0;
        end else if (phases != 4'h0 && phases != last_pat) begin
            idx = phases[1] ? 1 : phases[2] ? 2 : phases[3] ? 3 : 0;
            steps <= steps + 1;
            step_delta <= (idx - last_idx) & 3;
            last_idx <= idx;
            last_pat <= phases;
        end
    end
endmodule

// ===== msg_motor_signal_generator_test.sv
// Self-checking testbench for the motor signal generator.
`timescale 1ns/1ps
`include "msg_defs.vh"
module msg_motor_signal_generator_test;
    logic        clk = 0, rstn = 0;
    logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic        s_axi_bready = 1, s_axi_rready = 1;
    logic [31:0] s_axi_wdata = 0, seed = 32'h4667;
    logic [3:0]  s_axi_wstrb = 0;
    logic        timer3_full_match = 0, timer3_high_match = 0, timer3_16bit_mode = 0;
    logic        pll_clock_in = 0, low_freq_oscillator = 0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire         motor_out_0, motor_out_1, motor_out_2, motor_out_3, irq_request;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    int          n_mismatch = 0, num_checks = 0, steps, delta, tc = 0;
    msg_motor_signal_generator dut_u (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer3_full_match,
        .timer3_high_match, .timer3_16bit_mode, .pll_clock_in, .low_freq_oscillator,
        .motor_out_0, .motor_out_1, .motor_out_2, .motor_out_3, .irq_request);
    wire [3:0]   outs = {motor_out_3, motor_out_2, motor_out_1, motor_out_0};
    msg_motor_driver_model drv_u (.clk(clk), .rstn(rstn), .steps(steps), .step_delta(delta),
        .phases(outs));
    always #10 clk = ~clk;
    // ----------
    // Count clock sources
    // ----------
    always @(posedge clk) begin
        tc <= tc + 1;
        timer3_full_match <= (tc % 5 == 0);
        timer3_high_match <= (tc % 3 == 0);
        pll_clock_in <= tc[1];
        low_freq_oscillator <= tc[3];
    end
    // ----------
    // Tasks
    // ----------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pin(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [3:0] s = 4'hF,
                      input logic [1:0] er = `MSG_RESP_OKAY);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        chk_pin("awready while bvalid", 1'b0, s_axi_awready);
        chk_reg("bresp", er, s_axi_bresp);
    endtask
    task automatic rd(input logic [15:0] idx, output logic [31:0] d,
                      input logic [1:0] er = `MSG_RESP_OKAY);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        chk_pin("arready while rvalid", 1'b0, s_axi_arready);
        chk_reg("rresp", er, s_axi_rresp);
    endtask
    task automatic wait_steps(input int k);
        int n0;
        n0 = steps;
        for (int n = 0; n < 20000 && steps < n0 + k; n++) @(posedge clk);
        chk_pin("step progress", 1'b1, steps >= n0 + k);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ----------
    // Tests
    // ----------
    initial begin
        repeat (50000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
    initial begin
        logic [31:0] v;
        logic [7:0]  msk [6];
        logic [1:0]  ck;
        int          m [6];
        int          dl [2];
        int          s0;
        msk = '{8'hFF, 8'hFF, 8'hFF, `MSG_PHI_MASK, 8'hFF, `MSG_DHI_MASK};
        repeat (5) @(posedge clk);
        rstn <= 1;
        timer3_16bit_mode <= seed[0];
        @(posedge clk);
        for (int k = 0; k < 6; k++) begin
            rd(16'(`MSG_IDX_CTL + k), v);
            chk_reg("reset value", `MSG_RST_BYTE, v);
        end
        wr(`MSG_IDX_CTL, 8'hE0);
        rd(`MSG_IDX_CTL, v);
        chk_reg("flags after software set", 8'h00, v);
        wr(16'h7F86, 8'h55, 4'hF, `MSG_RESP_SLVERR);
        rd(16'h7F7F, v, `MSG_RESP_SLVERR);
        chk_reg("unmapped read", 32'h0, v);
        $display("reset and map test done");
        for (int r = 0; r < 3; r++) begin
            for (int k = 1; k < 6; k++) begin
                seed = lfsr(seed);
                wr(16'(`MSG_IDX_CTL + k), seed[7:0]);
                m[k] = seed[7:0] & msk[k];
            end
            wr(`MSG_IDX_STEP, ~m[1], 4'h0);
            for (int k = 1; k < 6; k++) begin
                rd(16'(`MSG_IDX_CTL + k), v);
                chk_reg("register readback", m[k], v);
            end
        end
        $display("register test done");
        wr(`MSG_IDX_STEP, 8'h00);
        wr(`MSG_IDX_PER_LO, 8'h28);
        wr(`MSG_IDX_DLY_LO, 8'h01);
        wr(`MSG_IDX_DLY_HI, 8'h00);
        for (int c = 0; c < 4; c++) begin
            ck = (c == 2) ? `MSG_COUNT_CLOCK_SELECT_OSC : (c == 3) ? `MSG_COUNT_CLOCK_SELECT_PLL : 2'(c);
            for (int dir = 0; dir < 2; dir++) begin
                wr(`MSG_IDX_PER_HI, (ck == `MSG_COUNT_CLOCK_SELECT_PLL) ? 8'h00 : {dir[0], 7'h0});
                wr(`MSG_IDX_CTL, {4'h0, ck, (ck == `MSG_COUNT_CLOCK_SELECT_PLL) & dir[0], 1'b1});
                wait_steps(3);
                dl[dir] = delta;
                wr(`MSG_IDX_CTL, 8'h00);
                repeat (3) @(posedge clk);
                chk_pin("outputs after stop", 1'b0, |outs);
            end
            chk_reg("direction reversal", 32'd4, dl[0] + dl[1]);
        end
        $display("clock select test done");
        wr(`MSG_IDX_PER_LO, 8'h10);
        wr(`MSG_IDX_STEP, 8'h02);
        wr(`MSG_IDX_CTL, 8'h11);
        wait_steps(7);
        rd(`MSG_IDX_CTL, v);
        chk_reg("match flags", 8'h31, v);
        chk_pin("irq raised", 1'b1, irq_request);
        for (int k = 0; k < 3; k++) begin
            wr(`MSG_IDX_CTL, (k == 1) ? 8'h30 : (k == 0) ? 8'h20 : 8'h10);
            repeat (3) @(posedge clk);
            chk_pin("irq level", k == 1, irq_request);
        end
        $display("match and interrupt test done");
        wr(`MSG_IDX_STEP, 8'h00);
        wr(`MSG_IDX_PER_LO, 8'h08);
        wr(`MSG_IDX_DLY_LO, 8'h00);
        s0 = steps;
        wr(`MSG_IDX_CTL, 8'h01);
        wait_steps(260);
        rd(`MSG_IDX_CTL, v);
        chk_reg("overflow flags", 8'h41, v);
        wr(`MSG_IDX_PER_HI, 8'h40);
        for (int n = 0; n < 100 && !v[7]; n++) rd(`MSG_IDX_CTL, v);
        chk_pin("stop flag", 1'b1, v[7]);
        repeat (4) @(posedge clk);
        s0 = steps - s0;
        repeat (40) @(posedge clk);
        chk_pin("outputs halted", 1'b0, |outs);
        rd(`MSG_IDX_STEP, v);
        s0 = (s0 - int'(v[7:0])) & 255;
        chk_pin("counter read", 1'b1, s0 == 0 || s0 == 1 || s0 == 255);
        wr(`MSG_IDX_CTL, 8'h00);
        wr(`MSG_IDX_PER_HI, 8'h00);
        rd(`MSG_IDX_STEP, v);
        chk_reg("setting read", 32'h0, v);
        $display("overflow and stop test done");
        test_done();
    end
endmodule
